// File: common/event_input_en_defs.svh
// register map, field positions, reset values and codes of the timer control
`ifndef EVENT_INPUT_EN_DEFS_SVH
`define EVENT_INPUT_EN_DEFS_SVH
// register indices; byte address is four times the index
`define EVENT_INPUT_EN_IDX_CTLB_CLR 4'h4
`define EVENT_INPUT_EN_IDX_CTLB_SET 4'h5
`define EVENT_INPUT_EN_IDX_EVCTL 4'h6
`define EVENT_INPUT_EN_IDX_IEN_CLR 4'h8
`define EVENT_INPUT_EN_IDX_IEN_SET 4'h9
`define EVENT_INPUT_EN_IDX_IFLAG 4'ha
`define EVENT_INPUT_EN_IDX_STATUS 4'hb
// control_b fields
`define EVENT_INPUT_EN_CB_DIR 0
`define EVENT_INPUT_EN_CB_LOCK 1
`define EVENT_INPUT_EN_CB_SINGLE 2
`define EVENT_INPUT_EN_CB_CMD_LO 5
`define EVENT_INPUT_EN_CB_CMD_HI 7
// event_control fields
`define EVENT_INPUT_EN_EV_ACT_LO 0
`define EVENT_INPUT_EN_EV_ACT_HI 2
`define EVENT_INPUT_EN_EV_INV 4
`define EVENT_INPUT_EN_EV_IN_EN 5
`define EVENT_INPUT_EN_EV_WRAP_EO 8
`define EVENT_INPUT_EN_EV_CH0_EO 12
`define EVENT_INPUT_EN_EV_CH1_EO 13
// interrupt enable / flag fields
`define EVENT_INPUT_EN_IRQ_WRAP 0
`define EVENT_INPUT_EN_IRQ_ERR 1
`define EVENT_INPUT_EN_IRQ_CH0 4
`define EVENT_INPUT_EN_IRQ_CH1 5
`define EVENT_INPUT_EN_IRQ_MASK 8'h33
// status fields
`define EVENT_INPUT_EN_ST_STOP 0
// reset values
`define EVENT_INPUT_EN_RST_CTLB 8'h00
`define EVENT_INPUT_EN_RST_EVCTL 16'h0000
`define EVENT_INPUT_EN_RST_IEN 8'h00
`define EVENT_INPUT_EN_RST_IFLAG 8'h00
`define EVENT_INPUT_EN_RST_STOP 1'b1
// command codes
`define EVENT_INPUT_EN_CMD_NONE 3'h0
`define EVENT_INPUT_EN_CMD_RETRIG 3'h1
`define EVENT_INPUT_EN_CMD_STOP 3'h2
`define EVENT_INPUT_EN_CMD_UPDATE 3'h3
`define EVENT_INPUT_EN_CMD_RDSYNC 3'h4
// event action codes
`define EVENT_INPUT_EN_ACT_OFF 3'h0
`define EVENT_INPUT_EN_ACT_RETRIG 3'h1
`define EVENT_INPUT_EN_ACT_COUNT 3'h2
`define EVENT_INPUT_EN_ACT_START 3'h3
`define EVENT_INPUT_EN_ACT_STAMP 3'h4
`define EVENT_INPUT_EN_ACT_PRD_WID 3'h5
`define EVENT_INPUT_EN_ACT_WID_PRD 3'h6
`define EVENT_INPUT_EN_ACT_WID 3'h7
// default prescaler division
`define EVENT_INPUT_EN_PRESC_DIV 16
`endif

// File: common/event_input_en_pkg.sv
// types shared by the timer command/event/interrupt control
package event_input_en_pkg;
  typedef struct packed {
    logic count_down;
    logic single_pass;
    logic buffer_lock;
  } event_input_en_mode_s;

  typedef struct packed {
    logic retrigger;
    logic stop;
    logic update;
    logic counter_value_sync_cmd;
  } event_input_en_cmd_s;

  typedef struct packed {
    logic retrigger;
    logic count;
    logic start;
    logic stamp;
    logic [1:0] period_capture;
    logic [1:0] width_capture;
  } event_input_en_event_action_s;

  typedef struct packed {
    logic wrap;
    logic err;
    logic [1:0] match;
  } event_input_en_core_evt_s;
endpackage

// File: logic/event_input_en_ctrl.sv
// timer command, control_b, event control and interrupt enable logic
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`include "event_input_en_defs.svh"

module event_input_en_ctrl #(
  parameter int ADDR_W = 12,
  parameter int PRESC_DIV = `EVENT_INPUT_EN_PRESC_DIV
) (
  input wire logic clk_sys,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // counting core
  input wire logic tc_enabled,
  input wire logic capture_mode_en,
  input wire logic hw_update_req,
  input wire event_input_en_pkg::event_input_en_core_evt_s core_evt,
  output event_input_en_pkg::event_input_en_mode_s mode,
  output event_input_en_pkg::event_input_en_cmd_s cmd_strobe,
  output logic buffer_load,
  output logic counter_halt,
  output event_input_en_pkg::event_input_en_event_action_s ev_action,
  output logic presc_tick,
  // event routing network
  input wire logic event_in,
  output logic wrap_event_out,
  output logic [1:0] chan_event_out,
  output logic irq
);
  import event_input_en_pkg::*;

  // parameters the decode and the 10-bit divider cannot serve
  if (ADDR_W < 6) begin : g_bad_addr_w
    $error("event_input_en_ctrl: ADDR_W must be at least 6");
  end
  if (PRESC_DIV < 1 || PRESC_DIV > 1024) begin : g_bad_presc
    $error("event_input_en_ctrl: PRESC_DIV must be 1 to 1024");
  end

  localparam int PRESC_W = 10;
  localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(PRESC_DIV - 1);
  localparam logic [15:0] EV_RST = `EVENT_INPUT_EN_RST_EVCTL;

  // bus decode
  logic [3:0] idx;
  logic hi_zero;
  logic mapped;
  logic wr;
  logic [7:0] wb0;
  logic [7:0] wb1;
  logic ctlb_set_wr;
  logic ctlb_clr_wr;
  logic ev_wr_lo;
  logic ev_wr_hi;
  logic ien_set_wr;
  logic ien_clr_wr;
  logic flag_wr;

  assign idx = paddr[5:2];
  assign hi_zero = ((paddr >> 6) == '0);
  assign wr = psel & penable & pwrite & mapped;
  assign wb0 = pwdata[7:0];
  assign wb1 = pwdata[15:8];
  assign ctlb_set_wr = wr & pstrb[0] & (idx == `EVENT_INPUT_EN_IDX_CTLB_SET);
  assign ctlb_clr_wr = wr & pstrb[0] & (idx == `EVENT_INPUT_EN_IDX_CTLB_CLR);
  assign ev_wr_lo = wr & pstrb[0] & (idx == `EVENT_INPUT_EN_IDX_EVCTL);
  assign ev_wr_hi = wr & pstrb[1] & (idx == `EVENT_INPUT_EN_IDX_EVCTL);
  assign ien_set_wr = wr & pstrb[0] & (idx == `EVENT_INPUT_EN_IDX_IEN_SET);
  assign ien_clr_wr = wr & pstrb[0] & (idx == `EVENT_INPUT_EN_IDX_IEN_CLR);
  assign flag_wr = wr & pstrb[0] & (idx == `EVENT_INPUT_EN_IDX_IFLAG);

  always_comb begin
    mapped = 1'b0;
    if (hi_zero && paddr[1:0] == 2'b00) begin
      unique case (idx)
        `EVENT_INPUT_EN_IDX_CTLB_CLR, `EVENT_INPUT_EN_IDX_CTLB_SET, `EVENT_INPUT_EN_IDX_EVCTL,
        `EVENT_INPUT_EN_IDX_IEN_CLR, `EVENT_INPUT_EN_IDX_IEN_SET, `EVENT_INPUT_EN_IDX_IFLAG,
        `EVENT_INPUT_EN_IDX_STATUS: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  end

  // prescaled timer tick
  logic [PRESC_W-1:0] presc_q;
  always_ff @(posedge clk_sys) begin
    if (srst || presc_q == PRESC_LAST) begin
      presc_q <= '0;
    end else begin
      presc_q <= presc_q + 1'b1;
    end
  end
  logic tick;
  assign tick = (presc_q == PRESC_LAST);

  // control_b state
  logic dir_q;
  logic lock_q;
  logic single_q;
  logic [2:0] cmd_q;
  logic [2:0] wcmd;
  assign wcmd = wb0[`EVENT_INPUT_EN_CB_CMD_HI:`EVENT_INPUT_EN_CB_CMD_LO];

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dir_q <= 1'b0;
    end else if (ctlb_set_wr && wb0[`EVENT_INPUT_EN_CB_DIR]) begin
      dir_q <= 1'b1;
    end else if (ctlb_clr_wr && wb0[`EVENT_INPUT_EN_CB_DIR]) begin
      dir_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      lock_q <= 1'b0;
    end else if (ctlb_set_wr && wb0[`EVENT_INPUT_EN_CB_LOCK]) begin
      lock_q <= 1'b1;
    end else if (ctlb_clr_wr && wb0[`EVENT_INPUT_EN_CB_LOCK]) begin
      lock_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      single_q <= 1'b0;
    end else if (ctlb_set_wr && wb0[`EVENT_INPUT_EN_CB_SINGLE]) begin
      single_q <= 1'b1;
    end else if (ctlb_clr_wr && wb0[`EVENT_INPUT_EN_CB_SINGLE]) begin
      single_q <= 1'b0;
    end
  end

  // a new command written in the tick cycle is held for the next tick; the old one still strobes
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cmd_q <= `EVENT_INPUT_EN_CMD_NONE;
    end else if (ctlb_set_wr && wcmd != `EVENT_INPUT_EN_CMD_NONE) begin
      cmd_q <= wcmd;
    end else if (ctlb_clr_wr && wcmd != `EVENT_INPUT_EN_CMD_NONE) begin
      cmd_q <= `EVENT_INPUT_EN_CMD_NONE;
    end else if (tick) begin
      cmd_q <= `EVENT_INPUT_EN_CMD_NONE;
    end
  end

  // command execution on the tick
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cmd_strobe <= '0;
    end else begin
      cmd_strobe.retrigger <= tick && cmd_q == `EVENT_INPUT_EN_CMD_RETRIG;
      cmd_strobe.stop <= tick && cmd_q == `EVENT_INPUT_EN_CMD_STOP;
      cmd_strobe.update <= tick && cmd_q == `EVENT_INPUT_EN_CMD_UPDATE;
      cmd_strobe.counter_value_sync_cmd <=
        tick && cmd_q == `EVENT_INPUT_EN_CMD_RDSYNC;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mode <= '0;
    end else begin
      mode.count_down <= dir_q;
      mode.single_pass <= single_q;
      mode.buffer_lock <= lock_q;
    end
  end

  // buffer loads: forced by command, or hardware update unless locked outside capture mode
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      buffer_load <= 1'b0;
    end else begin
      buffer_load <= (tick && cmd_q == `EVENT_INPUT_EN_CMD_UPDATE) ||
        (hw_update_req && (!lock_q || capture_mode_en));
    end
  end

  // single-pass halts after the wrap; otherwise the core keeps counting
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      counter_halt <= 1'b0;
    end else begin
      counter_halt <= (tick && cmd_q == `EVENT_INPUT_EN_CMD_STOP) ||
        (core_evt.wrap && single_q);
    end
  end

  // event_control
  logic [1:0] ch_eo_q;
  logic wrap_eo_q;
  logic ev_en_q;
  logic ev_inv_q;
  logic [2:0] ev_act_q;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ev_en_q <= EV_RST[`EVENT_INPUT_EN_EV_IN_EN];
      ev_inv_q <= EV_RST[`EVENT_INPUT_EN_EV_INV];
      ev_act_q <= EV_RST[`EVENT_INPUT_EN_EV_ACT_HI:`EVENT_INPUT_EN_EV_ACT_LO];
    end else if (ev_wr_lo) begin
      ev_en_q <= wb0[`EVENT_INPUT_EN_EV_IN_EN];
      ev_inv_q <= wb0[`EVENT_INPUT_EN_EV_INV];
      ev_act_q <= wb0[`EVENT_INPUT_EN_EV_ACT_HI:`EVENT_INPUT_EN_EV_ACT_LO];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wrap_eo_q <= EV_RST[`EVENT_INPUT_EN_EV_WRAP_EO];
      ch_eo_q <= EV_RST[`EVENT_INPUT_EN_EV_CH1_EO:`EVENT_INPUT_EN_EV_CH0_EO];
    end else if (ev_wr_hi) begin
      wrap_eo_q <= wb1[`EVENT_INPUT_EN_EV_WRAP_EO-8];
      ch_eo_q <= wb1[`EVENT_INPUT_EN_EV_CH1_EO-8:`EVENT_INPUT_EN_EV_CH0_EO-8];
    end
  end

  // event outputs to the routing network
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wrap_event_out <= 1'b0;
      chan_event_out <= 2'b00;
    end else begin
      wrap_event_out <= core_evt.wrap & wrap_eo_q;
      chan_event_out <= core_evt.match & ch_eo_q;
    end
  end

  // incoming event: edges of the polarised, gated source
  logic ev_src;
  logic ev_src_q;
  logic ev_rise;
  logic ev_fall;
  assign ev_src = event_in ^ ev_inv_q;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ev_src_q <= 1'b0;
    end else begin
      ev_src_q <= ev_src;
    end
  end
  assign ev_rise = ev_en_q & ev_src & ~ev_src_q;
  assign ev_fall = ev_en_q & ~ev_src & ev_src_q;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ev_action <= '0;
    end else begin
      ev_action <= '0;
      unique case (ev_act_q)
        `EVENT_INPUT_EN_ACT_OFF: ev_action <= '0;
        `EVENT_INPUT_EN_ACT_RETRIG: ev_action.retrigger <= ev_rise;
        `EVENT_INPUT_EN_ACT_COUNT: ev_action.count <= ev_rise;
        `EVENT_INPUT_EN_ACT_START: ev_action.start <= ev_rise;
        `EVENT_INPUT_EN_ACT_STAMP: ev_action.stamp <= ev_rise;
        `EVENT_INPUT_EN_ACT_PRD_WID: begin
          ev_action.period_capture <= {1'b0, ev_rise};
          ev_action.width_capture <= {ev_fall, 1'b0};
        end
        `EVENT_INPUT_EN_ACT_WID_PRD: begin
          ev_action.period_capture <= {ev_rise, 1'b0};
          ev_action.width_capture <= {1'b0, ev_fall};
        end
        `EVENT_INPUT_EN_ACT_WID: ev_action.width_capture <= {1'b0, ev_fall};
      endcase
    end
  end

  // stopped status; a stop cause wins over a start in the same cycle
  logic stop_q;
  logic stop_set;
  logic stop_clr;
  assign stop_set = !tc_enabled || (tick && cmd_q == `EVENT_INPUT_EN_CMD_STOP) ||
    (core_evt.wrap && single_q);
  assign stop_clr = (tick && cmd_q == `EVENT_INPUT_EN_CMD_RETRIG) ||
    (ev_rise && (ev_act_q == `EVENT_INPUT_EN_ACT_RETRIG ||
    ev_act_q == `EVENT_INPUT_EN_ACT_START));
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      stop_q <= `EVENT_INPUT_EN_RST_STOP;
    end else if (stop_set) begin
      stop_q <= 1'b1;
    end else if (stop_clr) begin
      stop_q <= 1'b0;
    end
  end

  // one enable state behind both enable registers
  logic [7:0] ien_q;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ien_q <= `EVENT_INPUT_EN_RST_IEN;
    end else if (ien_set_wr) begin
      ien_q <= ien_q | (wb0 & `EVENT_INPUT_EN_IRQ_MASK);
    end else if (ien_clr_wr) begin
      ien_q <= ien_q & ~(wb0 & `EVENT_INPUT_EN_IRQ_MASK);
    end
  end

  // interrupt flags; a hardware set beats a software clear
  logic [7:0] flag_q;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  always_comb begin
    flag_set = 8'h00;
    flag_set[`EVENT_INPUT_EN_IRQ_WRAP] = core_evt.wrap;
    flag_set[`EVENT_INPUT_EN_IRQ_ERR] = core_evt.err;
    flag_set[`EVENT_INPUT_EN_IRQ_CH0] = core_evt.match[0];
    flag_set[`EVENT_INPUT_EN_IRQ_CH1] = core_evt.match[1];
  end
  assign flag_clr = flag_wr ? (wb0 & `EVENT_INPUT_EN_IRQ_MASK) : 8'h00;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      flag_q <= `EVENT_INPUT_EN_RST_IFLAG;
    end else begin
      flag_q <= (flag_q & ~flag_clr) | flag_set;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flag_q & ien_q);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      presc_tick <= 1'b0;
    end else begin
      presc_tick <= tick;
    end
  end

  // read mux, captured in the setup phase
  logic [31:0] rd_d;
  logic [31:0] rd_q;
  logic [7:0] ctlb_rd;
  assign ctlb_rd = {cmd_q, 2'b00, single_q, lock_q, dir_q};
  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (idx)
      `EVENT_INPUT_EN_IDX_CTLB_CLR, `EVENT_INPUT_EN_IDX_CTLB_SET: rd_d[7:0] = ctlb_rd;
      `EVENT_INPUT_EN_IDX_EVCTL: begin
        rd_d[`EVENT_INPUT_EN_EV_CH1_EO:`EVENT_INPUT_EN_EV_CH0_EO] = ch_eo_q;
        rd_d[`EVENT_INPUT_EN_EV_WRAP_EO] = wrap_eo_q;
        rd_d[`EVENT_INPUT_EN_EV_IN_EN] = ev_en_q;
        rd_d[`EVENT_INPUT_EN_EV_INV] = ev_inv_q;
        rd_d[`EVENT_INPUT_EN_EV_ACT_HI:`EVENT_INPUT_EN_EV_ACT_LO] = ev_act_q;
      end
      `EVENT_INPUT_EN_IDX_IEN_CLR, `EVENT_INPUT_EN_IDX_IEN_SET: rd_d[7:0] = ien_q;
      `EVENT_INPUT_EN_IDX_IFLAG: rd_d[7:0] = flag_q;
      `EVENT_INPUT_EN_IDX_STATUS: rd_d[`EVENT_INPUT_EN_ST_STOP] = stop_q;
      default: rd_d = 32'h0000_0000;
    endcase
    if (!mapped) begin
      rd_d = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rd_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      rd_q <= rd_d;
    end
  end

  // zero wait states; unmapped or misaligned access errors
  assign prdata = rd_q;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
endmodule

// File: sim/event_input_en_far_model.sv
// far-side model: event routing source and counting core event pulses
`timescale 1ns/1ps
module event_input_en_far_model (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [3:0] fire,
  input wire logic evt_lvl,
  output event_input_en_pkg::event_input_en_core_evt_s core_evt,
  output logic event_in
);
  import event_input_en_pkg::*;
  // core events last one cycle; a held level would count twice
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      core_evt <= '0;
      event_in <= 1'b0;
    end else begin
      core_evt <= fire;
      event_in <= evt_lvl;
    end
  end
endmodule

// File: sim/event_input_en_ctrl_asserts.sv
// concurrent checks on the timer control ports
`timescale 1ns/1ps
module event_input_en_ctrl_asserts (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pslverr,
  input wire logic hw_update_req,
  input wire logic event_in,
  input wire event_input_en_pkg::event_input_en_core_evt_s core_evt,
  input wire event_input_en_pkg::event_input_en_cmd_s cmd_strobe,
  input wire logic buffer_load,
  input wire logic counter_halt,
  input wire event_input_en_pkg::event_input_en_event_action_s ev_action,
  input wire logic presc_tick,
  input wire logic wrap_event_out,
  input wire logic [1:0] chan_event_out,
  input wire logic irq
);
  import event_input_en_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  wrap_out_a: assert property (
    wrap_event_out |-> $past(core_evt.wrap)) else $error("wrap event unasked");
  chan_out_a: assert property (
    |chan_event_out |-> (chan_event_out & ~$past(core_evt.match)) == 2'b00)
    else $error("channel event unasked");
  cmd_tick_a: assert property (
    |cmd_strobe |-> presc_tick) else $error("command off the tick");
  cmd_single_a: assert property (
    $onehot0(cmd_strobe)) else $error("two commands at once");
  stop_halt_a: assert property (
    cmd_strobe.stop |-> counter_halt) else $error("stop did not halt");
  load_cause_a: assert property (
    buffer_load |-> $past(hw_update_req) || cmd_strobe.update)
    else $error("buffer load unasked");
  event_action_edge_a: assert property (
    |ev_action |-> $past(event_in) != $past(event_in, 2))
    else $error("action without input edge");
  slverr_acc_a: assert property (
    pslverr |-> psel && penable) else $error("error outside access");
  cover property (cmd_strobe.update ##0 buffer_load);
  cover property (|ev_action);
  cover property ($rose(irq));
endmodule

bind event_input_en_ctrl event_input_en_ctrl_asserts u_event_input_en_ctrl_asserts (
  .clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable),
  .pslverr(pslverr), .hw_update_req(hw_update_req), .event_in(event_in),
  .core_evt(core_evt), .cmd_strobe(cmd_strobe), .buffer_load(buffer_load),
  .counter_halt(counter_halt), .ev_action(ev_action),
  .presc_tick(presc_tick), .wrap_event_out(wrap_event_out),
  .chan_event_out(chan_event_out), .irq(irq));

// File: sim/event_input_en_ctrl_tb.sv
// self-checking bench for the timer command/event/irq control
`timescale 1ns/1ps
`include "event_input_en_defs.svh"
module event_input_en_ctrl_tb;
  import event_input_en_pkg::*;
  localparam int PD = 4;
  logic clk_sys, srst, psel, penable, pwrite, pready, pslverr, perr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic tc_enabled, capture_mode_en, hw_update_req, event_in, evt_lvl;
  logic buffer_load, counter_halt, presc_tick, wrap_event_out, irq;
  logic [1:0] chan_event_out;
  logic [3:0] fire;
  logic [16:0] seen;
  logic [7:0] acc;
  logic [63:0] act_tbl = {8'h01, 8'h09, 8'h06, 8'h10, 8'h20, 8'h40, 8'h80, 8'h00};
  event_input_en_core_evt_s core_evt;
  event_input_en_mode_s mode;
  event_input_en_cmd_s cmd_strobe;
  event_input_en_event_action_s ev_action;
  int error_cnt, cmp_count;
  wire logic [16:0] obs = {counter_halt, cmd_strobe, ev_action,
    wrap_event_out, chan_event_out, buffer_load};

  event_input_en_ctrl #(.PRESC_DIV(PD)) u_event_input_en_ctrl (.clk_sys(clk_sys), .srst(srst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tc_enabled(tc_enabled),
    .capture_mode_en(capture_mode_en), .hw_update_req(hw_update_req),
    .core_evt(core_evt), .mode(mode), .cmd_strobe(cmd_strobe),
    .buffer_load(buffer_load), .counter_halt(counter_halt),
    .ev_action(ev_action), .presc_tick(presc_tick), .event_in(event_in),
    .wrap_event_out(wrap_event_out), .chan_event_out(chan_event_out),
    .irq(irq));
  event_input_en_far_model u_event_input_en_far_model (.clk_sys(clk_sys), .srst(srst),
    .fire(fire), .evt_lvl(evt_lvl), .core_evt(core_evt),
    .event_in(event_in));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(string name, logic [31:0] got, logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic give_verdict();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic apb(logic [3:0] idx, logic wr, logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {6'h00, idx, 2'b00};
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) begin
      if (++n > 20) begin
        chk("apb wait", 1, 0);
        give_verdict();
      end
      @(posedge clk_sys);
    end
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // sampled just after each edge so one-cycle pulses are not missed
  task automatic watch(int n);
    seen = '0;
    repeat (n) begin
      #1;
      seen |= obs;
      @(posedge clk_sys);
    end
  endtask

  task automatic pulse(logic [3:0] f);
    @(posedge clk_sys);
    fire <= f;
    @(posedge clk_sys);
    fire <= 4'h0;
    watch(4);
  endtask

  task automatic upd(logic cap);
    @(posedge clk_sys);
    capture_mode_en <= cap;
    hw_update_req <= 1'b1;
    @(posedge clk_sys);
    hw_update_req <= 1'b0;
    watch(3);
  endtask

  task automatic t_reset();
    apb(`EVENT_INPUT_EN_IDX_EVCTL, 0, 0);
    chk("evctl reset", rd, 0);
    apb(`EVENT_INPUT_EN_IDX_IEN_SET, 0, 0);
    chk("ien reset", rd, 0);
    apb(`EVENT_INPUT_EN_IDX_STATUS, 0, 0);
    chk("status reset", rd, 1);
    apb(4'hf, 0, 0);
    chk("unmapped err", perr, 1);
    chk("unmapped data", rd, 0);
  endtask

  task automatic t_cmd();
    for (int c = 1; c <= 4; c++) begin
      apb(`EVENT_INPUT_EN_IDX_CTLB_SET, 1, c << 5);
      watch(3 * PD);
      chk("cmd strobe", seen[15:12], 4'b1000 >> (c - 1));
      chk("cmd load", seen[0], c == 3);
      apb(`EVENT_INPUT_EN_IDX_CTLB_SET, 0, 0);
      chk("cmd readback", rd, 0);
      apb(`EVENT_INPUT_EN_IDX_STATUS, 0, 0);
      if (c < 3) chk("stop flag", rd[0], c == 2);
    end
    apb(`EVENT_INPUT_EN_IDX_CTLB_SET, 1, 0);
    watch(3 * PD);
    chk("cmd zero", seen, 0);
  endtask

  task automatic t_mode();
    apb(`EVENT_INPUT_EN_IDX_CTLB_SET, 1, 8'h07);
    watch(2);
    chk("mode set", mode, 3'b111);
    apb(`EVENT_INPUT_EN_IDX_CTLB_SET, 1, 0);
    apb(`EVENT_INPUT_EN_IDX_CTLB_SET, 0, 0);
    chk("mode keep", rd, 8'h07);
    apb(`EVENT_INPUT_EN_IDX_CTLB_CLR, 1, 8'h01);
    watch(2);
    chk("count up", mode, 3'b011);
    upd(1'b0);
    chk("locked", seen[0], 0);
    upd(1'b1);
    chk("capture lock", seen[0], 1);
    apb(`EVENT_INPUT_EN_IDX_CTLB_CLR, 1, 8'h02);
    upd(1'b0);
    chk("unlocked", seen[0], 1);
  endtask

  task automatic t_evout();
    apb(`EVENT_INPUT_EN_IDX_CTLB_SET, 1, 32'h20);
    watch(3 * PD);
    apb(`EVENT_INPUT_EN_IDX_STATUS, 0, 0);
    chk("restart", rd[0], 0);
    apb(`EVENT_INPUT_EN_IDX_EVCTL, 1, 32'h3100);
    pulse(4'hb);
    chk("all out", seen[3:1], 3'b111);
    chk("single halt", seen[16], 1);
    apb(`EVENT_INPUT_EN_IDX_STATUS, 0, 0);
    chk("single stop", rd[0], 1);
    apb(`EVENT_INPUT_EN_IDX_EVCTL, 1, 32'h1000);
    apb(`EVENT_INPUT_EN_IDX_CTLB_CLR, 1, 8'h04);
    pulse(4'hb);
    chk("ch0 only", seen[3:1], 3'b001);
    chk("free run", seen[16], 0);
  endtask

  task automatic t_event_action();
    for (int a = 0; a < 8; a++) begin
      apb(`EVENT_INPUT_EN_IDX_EVCTL, 1, 32'h20 | a);
      evt_lvl <= 1'b1;
      watch(5);
      acc = seen[11:4];
      evt_lvl <= 1'b0;
      watch(5);
      chk("action", acc | seen[11:4], act_tbl[a*8+:8]);
    end
    apb(`EVENT_INPUT_EN_IDX_EVCTL, 1, 32'h02);
    evt_lvl <= 1'b1;
    watch(5);
    chk("input off", seen[11:4], 0);
    apb(`EVENT_INPUT_EN_IDX_EVCTL, 1, 32'h12);
    evt_lvl <= 1'b0;
    apb(`EVENT_INPUT_EN_IDX_EVCTL, 1, 32'h32);
    evt_lvl <= 1'b1;
    watch(5);
    chk("inv fall", seen[11:4], 0);
    evt_lvl <= 1'b0;
    watch(5);
    chk("inv rise", seen[11:4], 8'h40);
    apb(`EVENT_INPUT_EN_IDX_STATUS, 0, 0);
    chk("event start", rd[0], 0);
    tc_enabled <= 1'b0;
    apb(`EVENT_INPUT_EN_IDX_STATUS, 0, 0);
    chk("disabled stop", rd[0], 1);
    tc_enabled <= 1'b1;
  endtask

  // reset again mid-run, after every register has been written
  task automatic t_rerst();
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset();
  endtask

  task automatic t_irq();
    apb(`EVENT_INPUT_EN_IDX_IFLAG, 1, 8'h33);
    apb(`EVENT_INPUT_EN_IDX_IEN_SET, 1, 8'h33);
    apb(`EVENT_INPUT_EN_IDX_IEN_CLR, 0, 0);
    chk("ien shared", rd, 8'h33);
    pulse(4'h8);
    chk("irq wrap", irq, 1);
    apb(`EVENT_INPUT_EN_IDX_IEN_CLR, 1, 8'h01);
    apb(`EVENT_INPUT_EN_IDX_IEN_CLR, 1, 0);
    apb(`EVENT_INPUT_EN_IDX_IEN_SET, 0, 0);
    chk("ien clr wrap", rd, 8'h32);
    chk("irq masked", irq, 0);
    apb(`EVENT_INPUT_EN_IDX_IEN_CLR, 1, 8'h32);
    apb(`EVENT_INPUT_EN_IDX_IEN_SET, 0, 0);
    chk("ien clr rest", rd, 0);
    pulse(4'h1);
    chk("irq off", irq, 0);
    apb(`EVENT_INPUT_EN_IDX_IEN_SET, 1, 8'h10);
    watch(2);
    chk("irq ch0", irq, 1);
    apb(`EVENT_INPUT_EN_IDX_IFLAG, 1, 8'h10);
    watch(2);
    chk("irq cleared", irq, 0);
  endtask

  // hang guard for waits that no local bound covers
  initial begin
    repeat (20000) @(posedge clk_sys);
    chk("run time", 1, 0);
    give_verdict();
  end

  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    tc_enabled = 1'b1;
    capture_mode_en = 1'b0;
    hw_update_req = 1'b0;
    evt_lvl = 1'b0;
    fire = 4'h0;
    error_cnt = 0;
    cmp_count = 0;
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset();
    t_cmd();
    t_mode();
    t_evout();
    t_event_action();
    t_irq();
    t_rerst();
    give_verdict();
  end
endmodule
